// >>> hdl/ods_decode.sv
// Channel address decoder, one-hot select
`timescale 1ns/100ps
module ods_decode #(
    parameter int ADDR_W = ods_pkg::ADDR_W,
    parameter int NUM_CH = ods_pkg::NUM_CH
) (
    // Address in
    input wire logic [ADDR_W-1:0] addr,
    // Select out
    output logic [NUM_CH-1:0] sel
);
    always_comb
    begin
        sel = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            // Codes equal to or above the channel count select nothing
            if (addr == ADDR_W'(i))
            begin
                sel[i] = 1'b1;
            end
        end
    end
endmodule

// >>> hdl/ods_loader.sv
// Top: serial loader and eight channel holding registers
`timescale 1ns/100ps
module ods_loader #(
    parameter int NUM_CH = ods_pkg::NUM_CH,
    parameter int DATA_W = ods_pkg::DATA_W,
    parameter int ADDR_W = ods_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Serial link pins
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic transfer_strobe,
    input wire logic midscale_preset_n,
    output logic serial_out,
    // Channel codes, channel i at bits i*DATA_W
    output logic [NUM_CH*DATA_W-1:0] channel_code,
    // Pulse when the strobe loads any channel register; preset writes give none
    output logic channel_update
);
    localparam int WORD_W = ADDR_W + DATA_W;

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    // Preset travels inverted so the zero reset of the flops is its idle
    logic [3:0] pins_sync;

    ods_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in({~midscale_preset_n, transfer_strobe, serial_in,
                   serial_clk}),
        .sync_out(pins_sync)
    );

    logic sclk_s;
    logic sdata_s;
    logic strobe_s;
    logic preset_n_s;

    always_comb
    begin
        sclk_s = pins_sync[0];
        sdata_s = pins_sync[1];
        strobe_s = pins_sync[2];
        preset_n_s = !pins_sync[3];
    end

    // -----------------------------------------------------------------
    // Serial shift register
    // -----------------------------------------------------------------
    logic sclk_d_ff;
    logic nxt_sclk_d;
    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] nxt_shift;
    logic sout_ff;
    logic nxt_sout;
    logic sclk_rise;

    always_comb
    begin
        nxt_sclk_d = sclk_s;
        sclk_rise = sclk_s && !sclk_d_ff;
        nxt_shift = shift_ff;
        if (sclk_rise)
        begin
            // New bit enters at the LSB; older bits move toward MSB
            nxt_shift = {shift_ff[WORD_W-2:0], sdata_s};
        end
        // Far end of the register; chained part sees bit after 12 clocks
        nxt_sout = nxt_shift[WORD_W-1];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_d_ff <= 1'b0;
            shift_ff <= ods_pkg::WORD_RST;
            sout_ff <= 1'b0;
        end
        else
        begin
            sclk_d_ff <= nxt_sclk_d;
            shift_ff <= nxt_shift;
            sout_ff <= nxt_sout;
        end
    end

    // -----------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------
    logic [ADDR_W-1:0] word_addr;
    logic [DATA_W-1:0] word_data;
    logic [NUM_CH-1:0] ch_sel;

    always_comb
    begin
        // Twelve-bit word: address on top, data below
        word_addr = shift_ff[WORD_W-1:DATA_W];
        word_data = shift_ff[DATA_W-1:0];
    end

    ods_decode #(
        .ADDR_W(ADDR_W),
        .NUM_CH(NUM_CH)
    ) u_decode (
        .addr(word_addr),
        .sel(ch_sel)
    );

    // -----------------------------------------------------------------
    // Channel holding registers
    // -----------------------------------------------------------------
    // Level-sensitive load: bits shifting during a high strobe pass on
    logic [DATA_W-1:0] chan_ff [NUM_CH];
    logic [DATA_W-1:0] nxt_chan [NUM_CH];
    logic upd_ff;
    logic nxt_upd;
    logic [NUM_CH*DATA_W-1:0] code_ff;
    logic [NUM_CH*DATA_W-1:0] nxt_code;

    always_comb
    begin
        nxt_upd = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            nxt_chan[i] = chan_ff[i];
            if (!preset_n_s)
            begin
                // Preset dominates the strobe
                nxt_chan[i] = ods_pkg::MIDSCALE;
            end
            else if (strobe_s && ch_sel[i])
            begin
                // On a strobe only the shift register feeds the holding regs
                nxt_chan[i] = word_data;
                nxt_upd = 1'b1;
            end
        end
        for (int i = 0; i < NUM_CH; i++)
        begin
            // Unsigned code out; analog ladder does code/256
            nxt_code[i*DATA_W +: DATA_W] = nxt_chan[i];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                chan_ff[i] <= ods_pkg::MIDSCALE;
            end
            code_ff <= {NUM_CH{ods_pkg::MIDSCALE}};
            upd_ff <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                chan_ff[i] <= nxt_chan[i];
            end
            code_ff <= nxt_code;
            upd_ff <= nxt_upd;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign serial_out = sout_ff;
    assign channel_code = code_ff;
    assign channel_update = upd_ff;
endmodule

// >>> hdl/ods_pkg.sv
// Package: constants for the octal serial loader
package ods_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int WORD_W = ADDR_W + DATA_W;
    localparam int NUM_CH = 8;
    localparam logic [DATA_W-1:0] MIDSCALE = 8'h80;
    localparam logic [DATA_W-1:0] CODE_MAX = 8'hff;
    localparam int LADDER_DEN = 256;
    localparam int SYNC_STAGES = 2;
    localparam logic [WORD_W-1:0] WORD_RST = 12'h000;

    typedef enum logic [1:0]
    {
        ODS_IDLE = 2'b00,
        ODS_HOLD = 2'b01
    } ods_load_t;
endpackage

// >>> hdl/ods_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ods_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule

// >>> sim/ods_host.sv
// Host model driving the three-wire link
`timescale 1ns/100ps
module ods_host (
    // Timing
    input wire logic clk,
    // Link pins
    output logic serial_clk,
    output logic serial_in,
    output logic transfer_strobe,
    input wire logic serial_out,
    // Bits a chained device would have taken
    output logic [11:0] seen
);
    initial
    begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        transfer_strobe = 1'b0;
        seen = 12'h000;
    end
    // Address first, MSB first
    task automatic send(input logic [11:0] w, input int gap);
        for (int i = 11; i >= 0; i--)
        begin
            @(negedge clk);
            serial_in = w[i];
            repeat (8 + gap) @(negedge clk);
            seen = {seen[10:0], serial_out};
            serial_clk = 1'b1;
            repeat (8) @(negedge clk);
            serial_clk = 1'b0;
        end
        // Line is driven to the inverse of the last bit: no stale bit left on it
        serial_in = ~w[0];
    endtask
    // Strobe only after a whole word, link clock still
    task automatic load(input int len);
        repeat (4) @(negedge clk);
        transfer_strobe = 1'b1;
        repeat (len) @(negedge clk);
        transfer_strobe = 1'b0;
        repeat (8) @(negedge clk);
    endtask
endmodule

// >>> sim/ods_loader_properties.sv
// Port assertions for the serial loader
`timescale 1ns/100ps
module ods_props #(
    parameter int NUM_CH = 8,
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link pins
    input wire logic serial_clk,
    input wire logic transfer_strobe,
    input wire logic midscale_preset_n,
    input wire logic serial_out,
    // Channels
    input wire logic [NUM_CH*DATA_W-1:0] channel_code,
    input wire logic channel_update
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_preset_mid: assert property (
        !midscale_preset_n [*5] |-> channel_code == {NUM_CH{8'h80}})
        else $error("code not midscale");
    a_preset_block: assert property (
        !midscale_preset_n [*5] |-> !channel_update)
        else $error("load under preset");
    a_code_cause: assert property (
        $changed(channel_code) |-> channel_update
        || !$past(midscale_preset_n, 2) || !$past(midscale_preset_n, 3))
        else $error("code moved alone");
    a_update_cause: assert property (
        channel_update |-> $past(transfer_strobe, 3))
        else $error("update without strobe");
    a_update_end: assert property (
        $fell(transfer_strobe) |-> ##3 !channel_update)
        else $error("update outlived strobe");
    a_idle_hold: assert property (
        (midscale_preset_n && !transfer_strobe) [*5] |-> $stable(channel_code))
        else $error("code not held");
    a_shift_time: assert property (
        $changed(serial_out) |-> $past(serial_clk, 3)
        && !$past(serial_clk, 4))
        else $error("serial out off edge");
    a_serial_still: assert property (
        (!serial_clk) [*6] |-> $stable(serial_out))
        else $error("serial out moved");
endmodule

bind ods_loader ods_props #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) u_props (
    .clk(clk), .rstn(rstn), .serial_clk(serial_clk),
    .transfer_strobe(transfer_strobe), .midscale_preset_n(midscale_preset_n),
    .serial_out(serial_out), .channel_code(channel_code),
    .channel_update(channel_update));

// >>> sim/tb_octal_dac_serial_loader.sv
// Self-checking bench for the serial loader
`timescale 1ns/100ps
module tb_octal_dac_serial_loader;
    typedef struct packed
    {
        logic [11:0] word;
        logic upd;
    } ods_row_t;
    logic clk, rstn, sclk, sdin, strobe, preset_n, sdout, upd, upd_seen;
    logic [63:0] code, exp_code;
    logic [11:0] seen, prev;
    int err_count, tests_run;
    // Every channel, both code ends, both refused address ends
    ods_row_t rows [10] = '{'{12'h000, 1'b1}, '{12'h1ff, 1'b1},
        '{12'h255, 1'b1}, '{12'h3aa, 1'b1}, '{12'h401, 1'b1},
        '{12'h57f, 1'b1}, '{12'h680, 1'b1}, '{12'h7c3, 1'b1},
        '{12'h8de, 1'b0}, '{12'hf12, 1'b0}};
    ods_loader uut (.clk(clk), .rstn(rstn), .serial_clk(sclk),
        .serial_in(sdin), .transfer_strobe(strobe),
        .midscale_preset_n(preset_n), .serial_out(sdout),
        .channel_code(code), .channel_update(upd));
    ods_host host (.clk(clk), .serial_clk(sclk), .serial_in(sdin),
        .transfer_strobe(strobe), .serial_out(sdout), .seen(seen));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
        if (upd === 1'b1)
            upd_seen = 1'b1;
    task automatic check(input string what, input logic [63:0] e,
        input logic [63:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        rstn = 1'b0;
        preset_n = 1'b1;
        upd_seen = 1'b0;
        exp_code = {8{8'h80}};
        prev = 12'h000;
        repeat (4) @(negedge clk);
        check("reset code", exp_code, code);
        check("reset sdo", 64'h0, {63'h0, sdout});
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        foreach (rows[i])
        begin
            host.send(rows[i].word, i % 3);
            check("shift only", exp_code, code);
            check("chain", {52'h0, prev}, {52'h0, seen});
            upd_seen = 1'b0;
            host.load(6);
            // Codes 8..15 map to no channel
            if (!rows[i].word[11])
                exp_code[rows[i].word[10:8]*8 +: 8] = rows[i].word[7:0];
            check("code", exp_code, code);
            check("update", {63'h0, rows[i].upd}, {63'h0, upd_seen});
            prev = rows[i].word;
        end
        // Preset beats a strobe over a valid word
        host.send(12'h0aa, 0);
        preset_n = 1'b0;
        upd_seen = 1'b0;
        host.load(6);
        check("preset", {8{8'h80}}, code);
        check("preset upd", 64'h0, {63'h0, upd_seen});
        preset_n = 1'b1;
        // Slow host, shortest strobe
        host.send(12'h7ee, 5);
        host.load(1);
        check("short load", {8'hee, {7{8'h80}}}, code);
        end_sim;
    end
    initial
    begin
        #60000;
        err_count++;
        $display("wrong value watchdog exp done got hang");
        end_sim;
    end
endmodule
